// [hw/hbsc_device.sv]
/*
 * Serial control and status port of the triple half-bridge driver.
 * Assumes the power-stage conditions arrive as levels from analog blocks
 * on other clocks; they and all link pins are synchronised here.
 */
// Local design decisions: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module hbsc_device (
  input  wire logic            aclk,            // System clock, 50 MHz.
  input  wire logic            aresetn,         // Synchronous reset, active low.
  input  wire logic            standby_n,       // Inhibit input, low = standby.
  hbsc_link_if.device          link,            // Serial link.
  input  wire logic            thermal_warn,    // Temperature prewarning level.
  input  wire logic            thermal_trip,    // Thermal shutdown level.
  input  wire logic [5:0]      sw_overcurrent,  // Overcurrent per switch.
  input  wire logic [5:0]      sw_underload,    // Current below open threshold.
  input  wire logic            supply_low,      // Power-stage undervoltage.
  output logic       [5:0]     sw_on,           // Driver gate enables.
  output logic       [15:0]    ctrl_word        // Executed control word.
);
  logic       sel_s;
  logic       clk_s;
  logic       din_s;
  logic       warn_s;
  logic       trip_s;
  logic       uv_s;
  logic       stby_s;
  logic [5:0] oc_s;
  logic [5:0] ul_s;

  // ---------------------------------------------------------------------------
  // Synchronisers
  // ---------------------------------------------------------------------------
  hbsc_sync3 #(.INIT(1'b1)) u_sel  (.aclk(aclk), .aresetn(aresetn), .din(link.sel_n),
                                    .dout(sel_s));
  hbsc_sync3 #(.INIT(1'b0)) u_clk  (.aclk(aclk), .aresetn(aresetn), .din(link.sclk),
                                    .dout(clk_s));
  hbsc_sync3 #(.INIT(1'b0)) u_din  (.aclk(aclk), .aresetn(aresetn), .din(link.serial_in),
                                    .dout(din_s));
  hbsc_sync3 #(.INIT(1'b0)) u_warn (.aclk(aclk), .aresetn(aresetn), .din(thermal_warn),
                                    .dout(warn_s));
  hbsc_sync3 #(.INIT(1'b0)) u_trip (.aclk(aclk), .aresetn(aresetn), .din(thermal_trip),
                                    .dout(trip_s));
  hbsc_sync3 #(.INIT(1'b0)) u_uv   (.aclk(aclk), .aresetn(aresetn), .din(supply_low),
                                    .dout(uv_s));
  hbsc_sync3 #(.INIT(1'b0)) u_stby (.aclk(aclk), .aresetn(aresetn), .din(standby_n),
                                    .dout(stby_s));
  genvar gi;
  generate
    for (gi = 0; gi < hbsc_pkg::SW_COUNT; gi++) begin : g_sw
      hbsc_sync3 #(.INIT(1'b0)) u_oc (.aclk(aclk), .aresetn(aresetn),
                                      .din(sw_overcurrent[gi]), .dout(oc_s[gi]));
      hbsc_sync3 #(.INIT(1'b0)) u_ul (.aclk(aclk), .aresetn(aresetn),
                                      .din(sw_underload[gi]), .dout(ul_s[gi]));
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  logic        sel_d_reg;
  logic        sel_d_next;
  logic        clk_d_reg;
  logic        clk_d_next;
  logic [15:0] shin_reg;     // Incoming control bits.
  logic [15:0] shin_next;
  logic [15:0] shout_reg;    // Outgoing status bits.
  logic [15:0] shout_next;
  logic [4:0]  cnt_reg;      // Falling clock edges seen.
  logic [4:0]  cnt_next;
  logic        first_reg;    // No rising edge yet in this frame.
  logic        first_next;
  logic [15:0] ctrl_reg;
  logic [15:0] ctrl_next;
  logic [5:0]  dis_reg;      // Switches held off by a fault.
  logic [5:0]  dis_next;
  logic        short_reg;
  logic        short_next;
  logic        open_reg;
  logic        open_next;
  logic        psf_reg;
  logic        psf_next;
  logic        thlock_reg;
  logic        thlock_next;
  logic        sdo_reg;
  logic        sdo_next;
  logic        oe_reg;
  logic        oe_next;

  logic        sel_fall;
  logic        sel_rise;
  logic        clk_fall;
  logic        clk_rise;
  logic        clr;
  logic [5:0]  act;
  logic [5:0]  stat_sw;
  logic [15:0] status;
  localparam int BIT_SW_LO_C = hbsc_pkg::BIT_SW_LO;

  // Edge detection on the synchronised link pins.
  assign sel_fall = sel_d_reg & ~sel_s;
  assign sel_rise = ~sel_d_reg & sel_s;
  assign clk_fall = clk_d_reg & ~clk_s & ~sel_s;
  assign clk_rise = ~clk_d_reg & clk_s & ~sel_s;

  // Switches that are commanded on and not held off by any fault.
  assign act     = ctrl_reg[BIT_SW_LO_C +: 6] & ~dis_reg & {6{~uv_s & ~thlock_reg}};
  assign stat_sw = act;

  // Status word assembly; unused positions read low.
  always_comb begin
    status = 16'h0000;
    status[hbsc_pkg::BIT_THERMAL]          = warn_s;
    status[hbsc_pkg::BIT_SW_LO +: 6]       = stat_sw;
    status[hbsc_pkg::BIT_SHORT]            = short_reg;
    status[hbsc_pkg::BIT_OPEN]             = open_reg;
    status[hbsc_pkg::BIT_SUPPLY]           = psf_reg;
  end

  // Next-state logic for the serial port, control word and fault flags.
  always_comb begin
    sel_d_next  = sel_s;
    clk_d_next  = clk_s;
    shin_next   = shin_reg;
    shout_next  = shout_reg;
    cnt_next    = cnt_reg;
    first_next  = first_reg;
    ctrl_next   = ctrl_reg;
    dis_next    = dis_reg;
    thlock_next = thlock_reg | trip_s;
    sdo_next    = sdo_reg;
    oe_next     = ~sel_s;
    clr         = 1'b0;
    // Status is loaded at select, so bit zero can be read without clocks.
    if (sel_fall) begin
      shout_next = status;
      sdo_next   = status[0];
      cnt_next   = '0;
      first_next = 1'b1;
    end
    if (clk_fall) begin
      shin_next = {din_s, shin_reg[15:1]};
      // The count saturates far above sixteen, so an overlong frame is refused too.
      if (cnt_reg != 5'h1F) cnt_next = cnt_reg + 5'd1;
    end
    if (clk_rise) begin
      if (!first_reg) begin
        shout_next = {1'b0, shout_reg[15:1]};
        sdo_next   = shout_reg[1];
      end
      first_next = 1'b0;
    end
    if (sel_rise && cnt_reg == 5'(hbsc_pkg::WORD_BITS)) begin
      ctrl_next = shin_reg & hbsc_pkg::CTRL_USED;
      clr       = shin_reg[hbsc_pkg::BIT_CLEAR];
      // A thermal trip holds every switch off until a clear comes with the trip gone.
      if (clr && !trip_s) begin
        dis_next    = '0;
        thlock_next = 1'b0;
      end
    end
    // Overcurrent shutdown latches the affected switches off.
    if (ctrl_reg[hbsc_pkg::BIT_OCS]) dis_next = dis_next | (oc_s & ctrl_reg[BIT_SW_LO_C +: 6]);
    // Flags: a clear and a new event in one cycle leave the flag set.
    short_next = (short_reg & ~clr) | (|(oc_s & ctrl_reg[BIT_SW_LO_C +: 6]));
    open_next  = (open_reg & ~clr) | (|(ul_s & act));
    psf_next   = (psf_reg & ~clr) | uv_s;
    ctrl_word  = ctrl_reg;
  end

  // Register stage; standby acts like reset and clears the status flags.
  always_ff @(posedge aclk) begin
    if (!aresetn || !stby_s) begin
      sel_d_reg  <= 1'b1;
      clk_d_reg  <= 1'b0;
      shin_reg   <= 16'h0000;
      shout_reg  <= 16'h0000;
      cnt_reg    <= 5'h00;
      first_reg  <= 1'b1;
      ctrl_reg   <= hbsc_pkg::CTRL_RESET;
      dis_reg    <= 6'h00;
      short_reg  <= 1'b0;
      open_reg   <= 1'b0;
      psf_reg    <= 1'b0;
      thlock_reg <= 1'b0;
      sdo_reg    <= 1'b0;
      oe_reg     <= 1'b0;
    end else begin
      sel_d_reg  <= sel_d_next;
      clk_d_reg  <= clk_d_next;
      shin_reg   <= shin_next;
      shout_reg  <= shout_next;
      cnt_reg    <= cnt_next;
      first_reg  <= first_next;
      ctrl_reg   <= ctrl_next;
      dis_reg    <= dis_next;
      short_reg  <= short_next;
      open_reg   <= open_next;
      psf_reg    <= psf_next;
      thlock_reg <= thlock_next;
      sdo_reg    <= sdo_next;
      oe_reg     <= oe_next;
    end
  end

  // Driver outputs follow the executed word and faults.
  assign sw_on       = act;
  assign link.sdo_o  = sdo_reg;
  assign link.sdo_oe = oe_reg;
endmodule : hbsc_device

// [hw/hbsc_host.sv]
/*
 * Serial controller that sends control words to the half-bridge port.
 * Software reaches it over AXI4-Lite; the link clock is made by a divider.
 */
`timescale 1ns/1ps
module hbsc_host (
  input  wire logic        aclk,     // System clock, 50 MHz.
  input  wire logic        aresetn,  // Synchronous reset, active low.
  input  wire logic [3:0]  awaddr,   // Write address.
  input  wire logic        awvalid,  // Write address valid.
  output logic             awready,  // Write address ready.
  input  wire logic [31:0] wdata,    // Write data.
  input  wire logic [3:0]  wstrb,    // Write strobes.
  input  wire logic        wvalid,   // Write data valid.
  output logic             wready,   // Write data ready.
  output logic [1:0]       bresp,    // Write response.
  output logic             bvalid,   // Write response valid.
  input  wire logic        bready,   // Write response ready.
  input  wire logic [3:0]  araddr,   // Read address.
  input  wire logic        arvalid,  // Read address valid.
  output logic             arready,  // Read address ready.
  output logic [31:0]      rdata,    // Read data.
  output logic [1:0]       rresp,    // Read response.
  output logic             rvalid,   // Read data valid.
  input  wire logic        rready,   // Read data ready.
  hbsc_link_if.host        link      // Serial link.
);
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00, HS_LOW = 2'b01, HS_HIGH = 2'b10, HS_END = 2'b11
  } hbsc_hstate_t;

  hbsc_hstate_t st_reg, st_next;
  logic [15:0] tx_reg, tx_next, rx_reg, rx_next, stat_reg, stat_next;
  logic [4:0]  bit_reg, bit_next;
  logic [7:0]  div_reg, div_next;
  logic        sel_reg, sel_next, sck_reg, sck_next, go;
  logic        aw_reg, aw_next, w_reg, w_next, bv_reg, bv_next, bad_reg, bad_next;
  logic [3:0]  awa_reg, awa_next;
  logic [15:0] wd_reg, wd_next;
  logic        rv_reg, rv_next;
  logic [31:0] rd_reg, rd_next;
  logic [1:0]  rr_reg, rr_next;
  logic        sdo_s;

  hbsc_sync3 #(.INIT(1'b0)) u_sdo (.aclk(aclk), .aresetn(aresetn), .din(link.sdo_i),
                                   .dout(sdo_s));

  // AXI write channel: take address and data in either order, then answer.
  always_comb begin
    aw_next = aw_reg; w_next = w_reg; bv_next = bv_reg; bad_next = bad_reg;
    awa_next = awa_reg; wd_next = wd_reg; go = 1'b0;
    if (awvalid && !aw_reg && !bv_reg) begin aw_next = 1'b1; awa_next = awaddr; end
    if (wvalid && !w_reg && !bv_reg) begin w_next = 1'b1; wd_next = wdata[15:0]; end
    if (aw_reg && w_reg && st_reg == HS_IDLE) begin
      aw_next  = 1'b0; w_next = 1'b0; bv_next = 1'b1;
      // Words that would enter a test mode are refused with an error.
      bad_next = (awa_reg != hbsc_pkg::ADDR_CTRL) ||
                 ((wd_reg & hbsc_pkg::TEST_MASK) == hbsc_pkg::TEST_MASK);
      go       = !bad_next;
    end
    if (bv_reg && bready) bv_next = 1'b0;
  end
  assign awready = ~aw_reg & ~bv_reg;
  assign wready  = ~w_reg & ~bv_reg;
  assign bvalid  = bv_reg;
  assign bresp   = bad_reg ? hbsc_pkg::RESP_SLVERR : hbsc_pkg::RESP_OKAY;

  // AXI read channel: status, busy flag, error on unmapped offsets.
  always_comb begin
    rv_next = rv_reg; rd_next = rd_reg; rr_next = rr_reg;
    if (arvalid && !rv_reg) begin
      rv_next = 1'b1; rr_next = hbsc_pkg::RESP_OKAY; rd_next = 32'h0000_0000;
      unique case (araddr)
        hbsc_pkg::ADDR_STAT: rd_next = {16'h0000, stat_reg};
        hbsc_pkg::ADDR_BUSY: rd_next = {31'h0000_0000, st_reg != HS_IDLE};
        default:             rr_next = hbsc_pkg::RESP_SLVERR;
      endcase
    end else if (rv_reg && rready) rv_next = 1'b0;
  end
  assign arready = ~rv_reg;
  assign rvalid  = rv_reg;
  assign rdata   = rd_reg;
  assign rresp   = rr_reg;

  // Link sequencer: sixteen bits LSB first, data set on rising, taken on falling.
  always_comb begin
    st_next = st_reg; tx_next = tx_reg; rx_next = rx_reg; stat_next = stat_reg;
    bit_next = bit_reg; sel_next = sel_reg; sck_next = sck_reg;
    div_next = (div_reg == 8'(hbsc_pkg::HALF_CYC - 1)) ? 8'h00 : div_reg + 8'h01;
    unique case (st_reg)
      HS_IDLE: if (go) begin
        tx_next = wd_reg; sel_next = 1'b0; bit_next = '0;
        div_next = 8'h00; st_next = HS_LOW;
      end
      HS_LOW: if (div_reg == 8'(hbsc_pkg::HALF_CYC - 1)) begin
        sck_next = 1'b1; st_next = HS_HIGH;
        // Next bit goes out on the rising edge, so it is steady at the fall.
        if (bit_reg != 5'd0) tx_next = {1'b0, tx_reg[15:1]};
      end
      HS_HIGH: if (div_reg == 8'(hbsc_pkg::HALF_CYC - 1)) begin
        sck_next = 1'b0;
        rx_next  = {sdo_s, rx_reg[15:1]};
        bit_next = bit_reg + 5'd1;
        st_next  = (bit_reg == 5'(hbsc_pkg::WORD_BITS - 1)) ? HS_END : HS_LOW;
      end
      // Deselect for a further half period so the next frame cannot follow too closely.
      HS_END: if (div_reg == 8'(hbsc_pkg::HALF_CYC - 1)) begin
        if (!sel_reg) begin
          sel_next = 1'b1; stat_next = rx_reg;
        end else st_next = HS_IDLE;
      end
    endcase
  end

  // Registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_reg <= 1'b0; w_reg <= 1'b0; bv_reg <= 1'b0; bad_reg <= 1'b0;
      awa_reg <= 4'h0; wd_reg <= 16'h0000;
      rv_reg <= 1'b0; rd_reg <= 32'h0000_0000; rr_reg <= 2'b00;
      st_reg <= HS_IDLE; tx_reg <= 16'h0000; rx_reg <= 16'h0000;
      stat_reg <= 16'h0000; bit_reg <= 5'h00; div_reg <= 8'h00;
      sel_reg <= 1'b1; sck_reg <= 1'b0;
    end else begin
      aw_reg <= aw_next; w_reg <= w_next; bv_reg <= bv_next; bad_reg <= bad_next;
      awa_reg <= awa_next; wd_reg <= wd_next;
      rv_reg <= rv_next; rd_reg <= rd_next; rr_reg <= rr_next;
      st_reg <= st_next; tx_reg <= tx_next; rx_reg <= rx_next;
      stat_reg <= stat_next; bit_reg <= bit_next; div_reg <= div_next;
      sel_reg <= sel_next; sck_reg <= sck_next;
    end
  end

  assign link.sel_n     = sel_reg;
  assign link.sclk      = sck_reg;
  assign link.serial_in = tx_reg[0];
endmodule : hbsc_host

// [hw/hbsc_link_if.sv]
/*
 * Serial link between the controller and the half-bridge control port.
 * The testbench resolves the shared data-out wire from its enable.
 */
`timescale 1ns/1ps
interface hbsc_link_if;
  logic sel_n;      // Chip select, active low.
  logic sclk;       // Serial clock.
  logic serial_in;  // Data into the device.
  logic sdo_o;      // Device data out value.
  logic sdo_oe;     // Device data out enable.
  logic sdo_i;      // Resolved data out wire.

  modport device (input sel_n, input sclk, input serial_in, input sdo_i,
                  output sdo_o, output sdo_oe);
  modport host   (output sel_n, output sclk, output serial_in, input sdo_i);
endinterface : hbsc_link_if

// [hw/hbsc_pkg.sv]
/*
 * Constants shared by the serial control port of the triple half-bridge driver
 * and by the controller that drives it.
 * Assumes a single 50 MHz system clock in both ends.
 */
// Functional notes
// - Chip select falling starts a transfer.
// - Input sampled on every falling serial clock.
// - Host sends control word LSB first.
// - Control word applied only at chip select rise.
// - Output released while deselected, driven when selected.
// - Output changes on rising serial clock only; here it also takes status bit zero at chip select fall.
// - Status shifted out LSB first, prewarning first.
// - Clear bit resets supply, open, short flags.
// - Bits one to six switch the drivers.
// - Bit thirteen enables overcurrent shutdown.
// - Status bits one to six show switch state.
// - Status bit zero shows thermal prewarning.
// - Bit thirteen flags short-circuit shutdown.
// - Bit fourteen flags open load.
// - Bit fifteen flags supply undervoltage.
// - Reset: switches off, overcurrent shutdown on.
// - Host avoids test-mode patterns with bits 15,14,13.
// - Each transfer moves sixteen bits each way.
// - Select without clocks changes nothing.
// - Clear bit re-enables short-circuit disabled outputs.
// - Standby low turns off and clears everything.
package hbsc_pkg;

  // ---------------------------------------------------------------------------
  // Word layout
  // ---------------------------------------------------------------------------
  localparam int          WORD_BITS     = 16;
  localparam int          CNT_BITS      = 5;
  localparam int          BIT_CLEAR     = 0;
  localparam int          BIT_SW_LO     = 1;
  localparam int          SW_COUNT      = 6;
  localparam int          BIT_OCS       = 13;
  localparam int          BIT_THERMAL   = 0;
  localparam int          BIT_SHORT     = 13;
  localparam int          BIT_OPEN      = 14;
  localparam int          BIT_SUPPLY    = 15;
  localparam logic [15:0] CTRL_RESET    = 16'h2000;
  localparam logic [15:0] CTRL_USED     = 16'h207F;
  localparam logic [15:0] TEST_MASK     = 16'hE000;

  // ---------------------------------------------------------------------------
  // Controller register map (AXI4-Lite byte addresses) and timing
  // ---------------------------------------------------------------------------
  localparam logic [3:0]  ADDR_CTRL     = 4'h0;
  localparam logic [3:0]  ADDR_STAT     = 4'h4;
  localparam logic [3:0]  ADDR_BUSY     = 4'h8;
  localparam int          CLK_MHZ       = 50;
  localparam int          LINK_NS       = 1000;
  localparam int          HALF_CYC      = LINK_NS * CLK_MHZ / 2000;
  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_SLVERR   = 2'b10;

endpackage : hbsc_pkg

// [hw/hbsc_sync3.sv]
/*
 * Three-stage input synchroniser; the output moves only when the second
 * and third stages agree. Assumes an asynchronous input.
 */
`timescale 1ns/1ps
module hbsc_sync3 #(
  parameter logic INIT = 1'b0
) (
  input  wire logic aclk,     // System clock.
  input  wire logic aresetn,  // Synchronous reset, active low.
  input  wire logic din,      // Asynchronous input.
  output logic      dout      // Filtered, synchronised level.
);
  logic [2:0] stg_reg;
  logic [2:0] stg_next;
  logic       out_reg;
  logic       out_next;

  // Shift the stages and accept a change once stages two and three agree.
  always_comb begin
    stg_next = {stg_reg[1:0], din};
    out_next = (stg_reg[1] == stg_reg[2]) ? stg_reg[2] : out_reg;
  end

  // Register stage.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stg_reg <= {3{INIT}};
      out_reg <= INIT;
    end else begin
      stg_reg <= stg_next;
      out_reg <= out_next;
    end
  end

  assign dout = out_reg;
endmodule : hbsc_sync3

// [test/half_bridge_serial_control_bench.sv]
/*
 * Bench joining controller and driver port over the link interface.
 * Assumes the design's registers and AXI4-Lite timing from the package.
 */
`timescale 1ns/1ps
module half_bridge_serial_control_bench;
  logic        aclk = 1'b0, aresetn = 1'b0, standby_n = 1'b1, sdo_last = 1'b0;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        thermal_warn = 1'b0, supply_low = 1'b0;
  logic [5:0]  sw_overcurrent = 6'h00, sw_underload = 6'h00, sw_on;
  logic [15:0] ctrl_word, exp_ctrl = 16'h2000;
  int          n_fail = 0, compares = 0;

  hbsc_link_if u_hbsc_link_if ();
  hbsc_host u_hbsc_host (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .link(u_hbsc_link_if));
  hbsc_device u_hbsc_device (.aclk(aclk), .aresetn(aresetn), .standby_n(standby_n),
    .link(u_hbsc_link_if), .thermal_warn(thermal_warn), .thermal_trip(1'b0),
    .sw_overcurrent(sw_overcurrent), .sw_underload(sw_underload), .supply_low(supply_low),
    .sw_on(sw_on), .ctrl_word(ctrl_word));
  hbsc_link_chk u_hbsc_link_chk (.aclk(aclk), .aresetn(aresetn),
    .sel_n(u_hbsc_link_if.sel_n), .sclk(u_hbsc_link_if.sclk),
    .serial_in(u_hbsc_link_if.serial_in), .sdo_o(u_hbsc_link_if.sdo_o),
    .sdo_oe(u_hbsc_link_if.sdo_oe));

  // A released data line shows the inverse of its last driven value.
  always @(posedge aclk) if (u_hbsc_link_if.sdo_oe) sdo_last <= u_hbsc_link_if.sdo_o;
  assign u_hbsc_link_if.sdo_i = u_hbsc_link_if.sdo_oe ? u_hbsc_link_if.sdo_o : ~sdo_last;
  always #10 aclk = ~aclk;

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic axi_wr(input logic [3:0] a, input logic [15:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a; wdata <= {16'h0000, d}; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    fork
      begin do @(posedge aclk); while (awready !== 1'b1); awvalid <= 1'b0; end
      begin do @(posedge aclk); while (wready !== 1'b1); wvalid <= 1'b0; end
    join
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  // Sends one control word and checks it is executed only at frame end.
  task automatic frame(input logic [15:0] w);
    logic [31:0] d;
    logic [1:0]  r;
    axi_wr(hbsc_pkg::ADDR_CTRL, w, r);
    chk("bresp", 16'(hbsc_pkg::RESP_OKAY), 16'(r));
    repeat (400) @(posedge aclk);
    chk("ctrl mid frame", exp_ctrl, ctrl_word);
    do axi_rd(hbsc_pkg::ADDR_BUSY, d, r); while (d[0] !== 1'b0);
    repeat (8) @(posedge aclk);
    exp_ctrl = w & hbsc_pkg::CTRL_USED;
    chk("ctrl executed", exp_ctrl, ctrl_word);
  endtask : frame

  task automatic stat(input logic [15:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(hbsc_pkg::ADDR_STAT, d, r);
    chk("status", e, d[15:0]);
  endtask : stat

  task automatic t_switch();
    frame(16'h202A);
    chk("low switches", 16'h0015, 16'(sw_on));
    frame(16'h2054);
    chk("high switches", 16'h002A, 16'(sw_on));
    frame(16'h202A);
  endtask : t_switch

  task automatic t_flags();
    thermal_warn <= 1'b1; supply_low <= 1'b1;
    repeat (20) @(posedge aclk);
    supply_low <= 1'b0;
    repeat (10) @(posedge aclk);
    // Underload counts only on a switch that is on, so it follows the undervoltage.
    sw_underload <= 6'h01;
    repeat (20) @(posedge aclk);
    sw_underload <= 6'h00;
    repeat (10) @(posedge aclk);
    frame(16'h202A);
    stat(16'hC02B);
    thermal_warn <= 1'b0;
    frame(16'h202B);
    frame(16'h202A);
    stat(16'h002A);
  endtask : t_flags

  task automatic t_short();
    sw_overcurrent <= 6'h01;
    repeat (20) @(posedge aclk);
    chk("short off", 16'h0014, 16'(sw_on));
    sw_overcurrent <= 6'h00;
    frame(16'h202A);
    stat(16'h2028);
    frame(16'h202B);
    chk("short re-enable", 16'h0015, 16'(sw_on));
    frame(16'h002A);
    sw_overcurrent <= 6'h01;
    repeat (20) @(posedge aclk);
    chk("no shutdown", 16'h0015, 16'(sw_on));
    sw_overcurrent <= 6'h00;
    frame(16'h002B);
    stat(16'h202A);
  endtask : t_short

  task automatic t_unmapped();
    logic [31:0] d;
    logic [1:0]  r;
    axi_wr(4'hC, 16'h207F, r);
    chk("write slverr", 16'(hbsc_pkg::RESP_SLVERR), 16'(r));
    axi_rd(4'hC, d, r);
    chk("read slverr", 16'(hbsc_pkg::RESP_SLVERR), 16'(r));
    chk("read data", 16'h0000, d[15:0]);
    axi_wr(hbsc_pkg::ADDR_CTRL, 16'hE07F, r);
    chk("test pattern", 16'(hbsc_pkg::RESP_SLVERR), 16'(r));
    axi_rd(hbsc_pkg::ADDR_BUSY, d, r);
    chk("test pattern busy", 16'h0000, d[15:0]);
  endtask : t_unmapped

  task automatic t_standby();
    frame(16'h202A);
    standby_n <= 1'b0;
    repeat (10) @(posedge aclk);
    chk("standby switches", 16'h0000, 16'(sw_on));
    chk("standby ctrl", 16'h2000, ctrl_word);
    standby_n <= 1'b1;
    repeat (10) @(posedge aclk);
    exp_ctrl = 16'h2000;
    frame(16'h2000);
    stat(16'h0000);
  endtask : t_standby

  task automatic report_and_stop();
    $display("Compares %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  // Main sequence: reset, then each scenario in turn.
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
    chk("reset ctrl", 16'h2000, ctrl_word);
    chk("reset switches", 16'h0000, 16'(sw_on));
    t_switch();
    t_flags();
    t_short();
    frame(16'h5F80);
    t_unmapped();
    t_standby();
    report_and_stop();
  end

  // Watchdog against a hang.
  initial begin
    repeat (60000) @(posedge aclk);
    n_fail++;
    report_and_stop();
  end
endmodule : half_bridge_serial_control_bench

// [test/hbsc_link_chk.sv]
/*
 * Checker of the serial link between controller and driver port.
 * Assumes it is instantiated beside the link interface on the 50 MHz clock.
 */
`timescale 1ns/1ps
module hbsc_link_chk (
  input wire logic aclk,       // System clock.
  input wire logic aresetn,    // Synchronous reset, active low.
  input wire logic sel_n,      // Chip select, active low.
  input wire logic sclk,       // Serial clock.
  input wire logic serial_in,  // Data into the device.
  input wire logic sdo_o,      // Device data out value.
  input wire logic sdo_oe      // Device data out enable.
);
  logic       sclk_reg;
  logic       sclk_next;
  logic [4:0] fall_reg;
  logic [4:0] fall_next;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Counts falling serial clock edges within the current frame.
  always_comb begin
    sclk_next = sclk;
    fall_next = fall_reg;
    if (sel_n) fall_next = 5'h00;
    else if (sclk_reg && !sclk) fall_next = fall_reg + 5'h01;
  end

  // Registers the edge detector and the count.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sclk_reg <= 1'b0;
      fall_reg <= 5'h00;
    end else begin
      sclk_reg <= sclk_next;
      fall_reg <= fall_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  AST_DO_RELEASED: assert property (sel_n [*6] |-> !sdo_oe)
    else $error("Data out driven while deselected.");
  AST_DO_DRIVEN: assert property ($fell(sel_n) |-> ##[1:6] sdo_oe)
    else $error("Data out not driven after select.");
  AST_DO_HOLD_LOW: assert property (
    (!sclk) [*8] ##0 (sdo_oe && $past(sdo_oe, 3)) |-> $stable(sdo_o))
    else $error("Data out moved while clock low.");
  AST_DO_HOLD_HIGH: assert property (sclk [*8] ##0 sdo_oe |-> $stable(sdo_o))
    else $error("Data out moved while clock high.");
  AST_CLK_IN_FRAME: assert property ($rose(sclk) |-> !sel_n)
    else $error("Serial clock outside a frame.");
  AST_SETUP_GAP: assert property ($fell(sel_n) |-> (!sclk) [*8] ##0 (!sel_n))
    else $error("Clock too soon after select.");
  AST_DATA_STEADY: assert property (sclk && $past(sclk) |-> $stable(serial_in))
    else $error("Serial input moved while clock high.");
  AST_SIXTEEN_FALLS: assert property ($rose(sel_n) |-> fall_reg == 5'h10)
    else $error("Frame without sixteen clock falls.");
endmodule : hbsc_link_chk
